//--- ldc_cfg.svh
// Timing, field and reset constants of the LED dimming control pin logic
//
// Behaviour
// R1: Pin low continuously over 2.5 ms puts the device in shutdown.
// R2: In shutdown the power switch never switches.
// R3: Mode is chosen anew at each enable; PWM unless entry pattern seen.
// R4: Rising pin in shutdown enables and starts the detection window timer.
// R5: Host waits 100 us after enable, then holds pin low over 260 us.
// R6: Qualifying low must finish inside the 1 ms window, else PWM mode.
// R7: One-wire mode starts at once; traffic accepted before the window ends.
// R8: Selected mode holds until a 2.5 ms shutdown and a fresh enable.
// R9: PWM pin held constantly high gives the full 200 mV reference.
// R10: PWM mode chops 200 mV with the duty and low-pass filters it.
// R11: Host keeps PWM frequency between 5 kHz and 100 kHz.
// R12: One-wire command sets the reference to one of 32 steps.
// R13: Codes map to 0,5,8,11, 3 mV to 38, 6 mV to 104, 12 mV to 200.
// R14: Stored step starts at full scale; received step held in a register.
// R15: Power reset returns the stored step to full scale.
// R16: Command is address byte then data byte; address must be 72 hex.
// R17: Data byte holds ack request, two select bits, five brightness bits.
// R18: Ack on request only when the whole command was received correctly.
// R19: Bit decoding is rate independent, 1.7 to 160 kbit/s.
// R20: Data bit 7 ack request, bits 6..5 select as zero, 4..0 code.
// R21: Ack is an open-drain low pull; host needs open-drain with pull-up.
// R22: Ack held low at most 512 us, then the line is released.
// R23: Bits MSB first; high longer than low is one, low longer is zero.
// R24: Bad address or malformed bits: brightness unchanged, no ack.
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH

`define LDC_CLK_MHZ 200.0
`define LDC_T_SHDN_MS 2.5
`define LDC_T_DELAY_US 100.0
`define LDC_T_HOLD_US 260.0
`define LDC_T_WIN_MS 1.0
`define LDC_T_ACK_US 512.0
`define LDC_T_BIT_TMO_US 1200.0
`define LDC_SHDN_CYC $rtoi($ceil(`LDC_T_SHDN_MS * 1000.0 * `LDC_CLK_MHZ))
`define LDC_DELAY_CYC $rtoi($ceil(`LDC_T_DELAY_US * `LDC_CLK_MHZ))
`define LDC_HOLD_CYC $rtoi($ceil(`LDC_T_HOLD_US * `LDC_CLK_MHZ))
`define LDC_WIN_CYC $rtoi(`LDC_T_WIN_MS * 1000.0 * `LDC_CLK_MHZ)
`define LDC_ACK_CYC $rtoi(`LDC_T_ACK_US * `LDC_CLK_MHZ)
`define LDC_BIT_TMO_CYC $rtoi(`LDC_T_BIT_TMO_US * `LDC_CLK_MHZ)
`define LDC_CNT_W 20
`define LDC_FILT_SHIFT 16
`define LDC_FRAME_BITS 16
`define LDC_DEV_ADDR 8'h72
`define LDC_ACK_REQ_POS 7
`define LDC_SEL_HI_POS 6
`define LDC_SEL_LO_POS 5
`define LDC_CODE_MSB 4
`define LDC_CODE_LSB 0
`define LDC_CODE_FULL 5'h1F
`define LDC_REF_FULL_MV 8'hC8

`endif

//--- ldc_pkg.sv
// Types of the LED dimming control pin logic
package ldc_pkg;
  typedef enum logic [1:0] {
    LDC_SHDN = 2'b00,
    LDC_DETECT = 2'b01,
    LDC_WIRE = 2'b11,
    LDC_PWM = 2'b10
  } ldc_mode_type;
  typedef enum logic [1:0] {
    LDC_RX_WAIT_HIGH = 2'b00,
    LDC_RX_IDLE = 2'b01,
    LDC_RX_LOW = 2'b11,
    LDC_RX_HIGH = 2'b10
  } ldc_rx_state_type;
endpackage

//--- ldc_rx_if.sv
// Link between mode control and one-wire bit receiver
`timescale 1ns/1ps
interface ldc_rx_if;
  logic enable;
  logic frame_done;
  logic frame_ok;
  logic ack_req;
  logic [4:0] code;
  modport rx (input enable, output frame_done, frame_ok, ack_req, code);
  modport ctl (output enable, input frame_done, frame_ok, ack_req, code);
endinterface

//--- ldc_bit_rx.sv
// One-wire bit and frame receiver
`timescale 1ns/1ps
`include "ldc_cfg.svh"
module ldc_bit_rx #(
  parameter int CNT_W = `LDC_CNT_W,
  parameter int BIT_TMO_CYC = `LDC_BIT_TMO_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic line_s,
  ldc_rx_if.rx rx
);
  localparam logic [CNT_W-1:0] TMO_LIM = CNT_W'(BIT_TMO_CYC);
  localparam logic [4:0] LAST_BIT = 5'(`LDC_FRAME_BITS - 1);

  ldc_pkg::ldc_rx_state_type state_r;
  logic [CNT_W-1:0] low_cnt_r;
  logic [CNT_W-1:0] high_cnt_r;
  logic [4:0] bits_r;
  logic [15:0] shift_r;
  logic err_r;
  logic done_r;
  logic ok_r;
  logic ack_req_r;
  logic [4:0] code_r;
  logic bit_val;
  logic bit_bad;
  logic [15:0] word_nxt;
  logic word_ok;

  // Ratio decode of the finished bit
  always_comb begin
    bit_val = high_cnt_r > low_cnt_r; // [R23] [R19]
    bit_bad = high_cnt_r == low_cnt_r;
    word_nxt = {shift_r[14:0], bit_val}; // [R23]
    word_ok = !err_r && !bit_bad
      && word_nxt[15:8] == `LDC_DEV_ADDR // [R16]
      && !word_nxt[`LDC_SEL_HI_POS] && !word_nxt[`LDC_SEL_LO_POS]; // [R20]
  end

  // =========================================
  // Bit state machine
  always_ff @(posedge clk) begin
    done_r <= 1'b0;
    if (!rstn || !rx.enable) begin
      state_r <= ldc_pkg::LDC_RX_WAIT_HIGH;
      low_cnt_r <= '0;
      high_cnt_r <= '0;
      bits_r <= '0;
      shift_r <= '0;
      err_r <= 1'b0;
      ok_r <= 1'b0;
    end else begin
      case (state_r)
        ldc_pkg::LDC_RX_WAIT_HIGH: begin
          if (line_s) begin
            state_r <= ldc_pkg::LDC_RX_IDLE;
          end
        end
        ldc_pkg::LDC_RX_IDLE: begin
          bits_r <= '0;
          err_r <= 1'b0;
          if (!line_s) begin
            state_r <= ldc_pkg::LDC_RX_LOW;
            low_cnt_r <= CNT_W'(1);
          end
        end
        ldc_pkg::LDC_RX_LOW: begin
          if (line_s) begin
            state_r <= ldc_pkg::LDC_RX_HIGH;
            high_cnt_r <= CNT_W'(1);
          end else if (low_cnt_r >= TMO_LIM) begin
            state_r <= ldc_pkg::LDC_RX_WAIT_HIGH; // [R24]
          end else begin
            low_cnt_r <= low_cnt_r + CNT_W'(1);
          end
        end
        ldc_pkg::LDC_RX_HIGH: begin
          if (!line_s) begin
            shift_r <= word_nxt;
            err_r <= err_r || bit_bad; // [R24]
            low_cnt_r <= CNT_W'(1);
            if (bits_r == LAST_BIT) begin
              done_r <= 1'b1;
              ok_r <= word_ok; // [R24]
              state_r <= ldc_pkg::LDC_RX_WAIT_HIGH;
            end else begin
              bits_r <= bits_r + 5'h01;
              state_r <= ldc_pkg::LDC_RX_LOW;
            end
          end else if (high_cnt_r >= TMO_LIM) begin
            state_r <= ldc_pkg::LDC_RX_IDLE; // [R24]
          end else begin
            high_cnt_r <= high_cnt_r + CNT_W'(1);
          end
        end
        default: begin
          state_r <= ldc_pkg::LDC_RX_WAIT_HIGH;
        end
      endcase
    end
  end

  // Captured fields of the last frame
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_req_r <= 1'b0;
      code_r <= '0;
    end else if (rx.enable && state_r == ldc_pkg::LDC_RX_HIGH && !line_s
                 && bits_r == LAST_BIT) begin
      ack_req_r <= word_nxt[`LDC_ACK_REQ_POS]; // [R17] [R20]
      code_r <= word_nxt[`LDC_CODE_MSB:`LDC_CODE_LSB]; // [R17]
    end
  end

  assign rx.frame_done = done_r;
  assign rx.frame_ok = ok_r;
  assign rx.ack_req = ack_req_r;
  assign rx.code = code_r;
endmodule // ldc_bit_rx

//--- ldc_top.sv
// Control pin logic: shutdown, mode choice, PWM and one-wire dimming
`timescale 1ns/1ps
`include "ldc_cfg.svh"
module ldc_top #(
  parameter int SHDN_CYC = `LDC_SHDN_CYC,
  parameter int DELAY_CYC = `LDC_DELAY_CYC,
  parameter int HOLD_CYC = `LDC_HOLD_CYC,
  parameter int WIN_CYC = `LDC_WIN_CYC,
  parameter int ACK_CYC = `LDC_ACK_CYC,
  parameter int BIT_TMO_CYC = `LDC_BIT_TMO_CYC,
  parameter int FILT_SHIFT = `LDC_FILT_SHIFT,
  parameter int CNT_W = `LDC_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ctrl_pin_i,
  output logic ctrl_pin_o,
  output logic ctrl_pin_oe,
  output logic shutdown_o,
  output logic switch_en_o,
  output logic wire_mode_o,
  output logic [7:0] ref_mv_o,
  output logic [4:0] bright_code_o,
  output logic cmd_accept_o
);
  localparam logic [CNT_W-1:0] SHDN_LIM = CNT_W'(SHDN_CYC);
  localparam logic [CNT_W-1:0] DELAY_LIM = CNT_W'(DELAY_CYC);
  localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] WIN_LIM = CNT_W'(WIN_CYC);
  localparam logic [CNT_W-1:0] ACK_LIM = CNT_W'(ACK_CYC - 1);
  localparam int ACC_W = 8 + FILT_SHIFT;

  // =========================================
  // Pin synchroniser and edges
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic pin_rise;
  logic pin_fall;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= ctrl_pin_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign pin_rise = sync2_r && !prev_r;
  assign pin_fall = !sync2_r && prev_r;

  // =========================================
  // Low time counter
  logic [CNT_W-1:0] low_cnt_r;
  logic long_low;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_cnt_r <= '0;
    end else if (sync2_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r <= SHDN_LIM) begin
      low_cnt_r <= low_cnt_r + CNT_W'(1);
    end
  end

  assign long_low = low_cnt_r > SHDN_LIM; // [R1]

  // =========================================
  // Mode state machine
  ldc_pkg::ldc_mode_type mode_r;
  ldc_pkg::ldc_mode_type mode_nxt;
  logic [CNT_W-1:0] win_cnt_r;
  logic qual_r;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      ldc_pkg::LDC_SHDN: begin
        if (pin_rise) begin
          mode_nxt = ldc_pkg::LDC_DETECT; // [R4] [R3]
        end
      end
      ldc_pkg::LDC_DETECT: begin
        if (qual_r && !sync2_r && low_cnt_r > HOLD_LIM
            && win_cnt_r < WIN_LIM) begin
          mode_nxt = ldc_pkg::LDC_WIRE; // [R5] [R6] [R7]
        end else if (win_cnt_r >= WIN_LIM) begin
          mode_nxt = ldc_pkg::LDC_PWM; // [R3] [R6]
        end
      end
      ldc_pkg::LDC_WIRE: begin
        mode_nxt = ldc_pkg::LDC_WIRE; // [R8]
      end
      ldc_pkg::LDC_PWM: begin
        mode_nxt = ldc_pkg::LDC_PWM; // [R8]
      end
      default: begin
        mode_nxt = ldc_pkg::LDC_SHDN;
      end
    endcase
    if (mode_r != ldc_pkg::LDC_SHDN && long_low) begin
      mode_nxt = ldc_pkg::LDC_SHDN; // [R1] [R8]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_r <= ldc_pkg::LDC_SHDN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Detection window timer from the first rising edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_cnt_r <= '0;
    end else if (mode_r != ldc_pkg::LDC_DETECT) begin
      win_cnt_r <= '0; // [R4]
    end else if (win_cnt_r < WIN_LIM) begin
      win_cnt_r <= win_cnt_r + CNT_W'(1);
    end
  end

  // Entry low must start after the detection delay
  always_ff @(posedge clk) begin
    if (!rstn) begin
      qual_r <= 1'b0;
    end else if (mode_r != ldc_pkg::LDC_DETECT || pin_rise) begin
      qual_r <= 1'b0;
    end else if (pin_fall) begin
      qual_r <= win_cnt_r >= DELAY_LIM; // [R5]
    end
  end

  // =========================================
  // One-wire receiver
  ldc_rx_if rx_bus ();
  logic ack_pend_r;
  logic ack_oe_r;
  logic [CNT_W-1:0] ack_cnt_r;
  logic good_cmd;

  assign rx_bus.enable = mode_r == ldc_pkg::LDC_WIRE
    && !ack_pend_r && !ack_oe_r; // [R7]
  assign good_cmd = rx_bus.frame_done && rx_bus.frame_ok
    && mode_r == ldc_pkg::LDC_WIRE;

  ldc_bit_rx #(
    .CNT_W(CNT_W),
    .BIT_TMO_CYC(BIT_TMO_CYC)
  ) u_rx (
    .clk(clk),
    .rstn(rstn),
    .line_s(sync2_r),
    .rx(rx_bus.rx)
  );

  // =========================================
  // Brightness step register
  logic [4:0] code_r;
  logic accept_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      code_r <= `LDC_CODE_FULL; // [R14] [R15]
    end else if (good_cmd) begin
      code_r <= rx_bus.code; // [R12] [R14] [R24]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      accept_r <= 1'b0;
    end else begin
      accept_r <= good_cmd;
    end
  end

  // =========================================
  // Acknowledge pull
  always_ff @(posedge clk) begin
    if (!rstn || mode_r != ldc_pkg::LDC_WIRE) begin
      ack_pend_r <= 1'b0;
      ack_oe_r <= 1'b0;
      ack_cnt_r <= '0;
    end else if (good_cmd && rx_bus.ack_req) begin
      ack_pend_r <= 1'b1; // [R18]
    end else if (ack_pend_r && sync2_r) begin
      ack_pend_r <= 1'b0;
      ack_oe_r <= 1'b1; // [R21]
      ack_cnt_r <= '0;
    end else if (ack_oe_r) begin
      if (ack_cnt_r >= ACK_LIM) begin
        ack_oe_r <= 1'b0; // [R22]
      end else begin
        ack_cnt_r <= ack_cnt_r + CNT_W'(1);
      end
    end
  end

  // =========================================
  // Reference for the feedback loop
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] tgt;
  logic signed [ACC_W:0] diff;
  logic signed [ACC_W:0] step;
  logic [7:0] ref_r;

  function automatic logic [7:0] ldc_code_mv(input logic [4:0] c);
    logic [7:0] cw;
    cw = {3'h0, c};
    if (c == 5'h00) begin
      ldc_code_mv = 8'h00;
    end else if (c <= 5'h0C) begin
      ldc_code_mv = 8'(8'h02 + 8'h03 * cw); // [R13]
    end else if (c <= 5'h17) begin
      ldc_code_mv = 8'(8'h26 + 8'h06 * (cw - 8'h0C)); // [R13]
    end else begin
      ldc_code_mv = 8'(8'h68 + 8'h0C * (cw - 8'h17)); // [R13]
    end
  endfunction

  // Chopped full scale, filtered with a first order low-pass
  always_comb begin
    tgt = sync2_r ? {`LDC_REF_FULL_MV, FILT_SHIFT'(0)} : '0; // [R10] [R9]
    diff = $signed({1'b0, tgt}) - $signed({1'b0, acc_r});
    step = diff >>> FILT_SHIFT;
    if (step == '0 && diff > '0) begin
      step = (ACC_W + 1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || mode_r == ldc_pkg::LDC_SHDN) begin
      acc_r <= '0;
    end else begin
      acc_r <= ACC_W'($signed({1'b0, acc_r}) + step); // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_r <= 8'h00;
    end else if (mode_nxt == ldc_pkg::LDC_SHDN) begin
      ref_r <= 8'h00;
    end else if (mode_nxt == ldc_pkg::LDC_WIRE) begin
      ref_r <= ldc_code_mv(good_cmd ? rx_bus.code : code_r); // [R12]
    end else begin
      ref_r <= acc_r[ACC_W-1 -: 8]; // [R10]
    end
  end

  // =========================================
  // Status outputs
  logic shdn_r;
  logic sw_en_r;
  logic wire_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shdn_r <= 1'b1;
      sw_en_r <= 1'b0;
      wire_r <= 1'b0;
    end else begin
      shdn_r <= mode_nxt == ldc_pkg::LDC_SHDN;
      sw_en_r <= mode_nxt != ldc_pkg::LDC_SHDN; // [R2]
      wire_r <= mode_nxt == ldc_pkg::LDC_WIRE;
    end
  end

  logic pin_o_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_o_r <= 1'b0;
    end else begin
      pin_o_r <= 1'b0; // [R21]
    end
  end

  assign ctrl_pin_o = pin_o_r;
  assign ctrl_pin_oe = ack_oe_r;
  assign shutdown_o = shdn_r;
  assign switch_en_o = sw_en_r;
  assign wire_mode_o = wire_r;
  assign ref_mv_o = ref_r;
  assign bright_code_o = code_r;
  assign cmd_accept_o = accept_r;
endmodule // ldc_top

//--- ldc_top_asserts.sv
// Assertions on the control pin logic ports
`timescale 1ns/1ps
module ldc_top_asserts #(
  parameter int SHDN_CYC = 2000,
  parameter int DELAY_CYC = 100,
  parameter int HOLD_CYC = 200,
  parameter int WIN_CYC = 1000,
  parameter int ACK_CYC = 50
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ctrl_pin_i,
  input wire logic ctrl_pin_o,
  input wire logic ctrl_pin_oe,
  input wire logic shutdown_o,
  input wire logic switch_en_o,
  input wire logic wire_mode_o,
  input wire logic [7:0] ref_mv_o,
  input wire logic [4:0] bright_code_o,
  input wire logic cmd_accept_o
);
  int low_r, en_r, oe_r;
  logic acc_r;
  // ==========
  // Run counters
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_r <= 0;
      en_r <= 0;
      oe_r <= 0;
      acc_r <= 1'b0;
    end else begin
      low_r <= ctrl_pin_i ? 0 : low_r + 1;
      en_r <= shutdown_o ? 0 : en_r + 1;
      oe_r <= ctrl_pin_oe ? oe_r + 1 : 0;
      acc_r <= cmd_accept_o | (acc_r & !ctrl_pin_oe & !shutdown_o);
    end
  end
  function automatic logic [7:0] lut(input logic [4:0] c);
    logic [7:0] w;
    w = {3'h0, c};
    if (c == 5'h00) return 8'h00;
    if (c < 5'h0D) return 8'h02 + 8'h03 * w;
    if (c < 5'h18) return 8'h26 + 8'h06 * (w - 8'h0C);
    return 8'h68 + 8'h0C * (w - 8'h17);
  endfunction
  // ==========
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence wire_rise;
    $rose(wire_mode_o);
  endsequence
  sequence ack_rise;
    $rose(ctrl_pin_oe);
  endsequence
  sequence ack_body;
    ctrl_pin_oe [*8];
  endsequence
  sw_off_a: assert property (
    shutdown_o |-> !switch_en_o && ref_mv_o == 8'h00)
    else $error("switch or reference active in shutdown");
  shdn_late_a: assert property (
    low_r > SHDN_CYC + 8 |-> shutdown_o)
    else $error("long low without shutdown");
  shdn_early_a: assert property (
    $rose(shutdown_o) |-> low_r > SHDN_CYC)
    else $error("shutdown too early");
  mode_keep_a: assert property (
    $fell(wire_mode_o) |-> shutdown_o)
    else $error("wire mode left without shutdown");
  entry_hold_a: assert property (
    wire_rise |-> low_r > HOLD_CYC && en_r >= DELAY_CYC + HOLD_CYC)
    else $error("wire mode entered without qualifying low");
  entry_win_a: assert property (
    wire_rise |-> en_r <= WIN_CYC + 2)
    else $error("wire mode entered after window");
  accept_pulse_a: assert property (
    cmd_accept_o |=> !cmd_accept_o)
    else $error("accept longer than one cycle");
  code_hold_a: assert property (
    $changed(bright_code_o) |-> cmd_accept_o)
    else $error("code changed without accept");
  ref_table_a: assert property (
    cmd_accept_o && wire_mode_o |-> ref_mv_o == lut(bright_code_o))
    else $error("reference does not match code");
  ack_cause_a: assert property (
    ack_rise |-> acc_r && wire_mode_o ##0 ack_body)
    else $error("ack without good command");
  ack_len_a: assert property (
    ctrl_pin_oe |-> oe_r < ACK_CYC && !ctrl_pin_o)
    else $error("ack too long or not a low pull");
endmodule // ldc_top_asserts

bind ldc_top ldc_top_asserts #(.SHDN_CYC(SHDN_CYC), .DELAY_CYC(DELAY_CYC),
  .HOLD_CYC(HOLD_CYC), .WIN_CYC(WIN_CYC), .ACK_CYC(ACK_CYC))
  ldc_top_asserts_inst (.clk(clk), .rstn(rstn), .ctrl_pin_i(ctrl_pin_i),
  .ctrl_pin_o(ctrl_pin_o), .ctrl_pin_oe(ctrl_pin_oe),
  .shutdown_o(shutdown_o), .switch_en_o(switch_en_o),
  .wire_mode_o(wire_mode_o), .ref_mv_o(ref_mv_o),
  .bright_code_o(bright_code_o), .cmd_accept_o(cmd_accept_o));

//--- ldc_host_model.sv
// Host model: open-drain control pin driver with pull-up
`timescale 1ns/1ps
module ldc_host_model (
  input wire logic clk,
  input wire logic dev_pull,
  output logic line
);
  logic host_low_r;
  // ==========
  // Line and bit driving
  assign line = !(host_low_r || dev_pull);
  initial host_low_r = 1'b1;
  task automatic drv(input logic lvl, input int n);
    @(posedge clk);
    host_low_r <= !lvl;
    repeat (n - 1) @(posedge clk);
  endtask
  task automatic bit_out(input logic b, input int u);
    drv(1'b0, b ? u : 2 * u);
    drv(1'b1, b ? 2 * u : u);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input int u);
    logic [15:0] w;
    w = {a, d};
    for (int i = 15; i >= 0; i--) bit_out(w[i], u);
    drv(1'b0, u);
    drv(1'b1, 100);
  endtask
endmodule // ldc_host_model

//--- tb_ldc_top.sv
// Testbench of the control pin logic
`timescale 1ns/1ps
module tb_ldc_top;
  localparam int SH = 2000;
  localparam int DLY = 100;
  localparam int HLD = 200;
  localparam int WIN = 1000;
  localparam int ACK = 50;
  logic clk, rstn, pin, ctrl_pin_o, ctrl_pin_oe, shutdown_o;
  logic switch_en_o, wire_mode_o, cmd_accept_o;
  logic [7:0] ref_mv_o;
  logic [4:0] bright_code_o;
  int miscompares = 0, samples_checked = 0, acc_n = 0, oe_n = 0;
  ldc_top #(.SHDN_CYC(SH), .DELAY_CYC(DLY), .HOLD_CYC(HLD), .WIN_CYC(WIN),
    .ACK_CYC(ACK), .BIT_TMO_CYC(400), .FILT_SHIFT(4), .CNT_W(20)) ldc_top_inst (
    .clk(clk), .rstn(rstn), .ctrl_pin_i(pin), .ctrl_pin_o(ctrl_pin_o),
    .ctrl_pin_oe(ctrl_pin_oe), .shutdown_o(shutdown_o),
    .switch_en_o(switch_en_o), .wire_mode_o(wire_mode_o),
    .ref_mv_o(ref_mv_o), .bright_code_o(bright_code_o),
    .cmd_accept_o(cmd_accept_o));
  ldc_host_model ldc_host_model_inst (.clk(clk),
    .dev_pull(ctrl_pin_oe && !ctrl_pin_o), .line(pin));
  // ==========
  // Helpers
  always @(posedge clk) begin
    if (cmd_accept_o === 1'b1) acc_n++;
    if (ctrl_pin_oe === 1'b1) oe_n++;
  end
  function automatic logic [7:0] lut(input int c);
    if (c == 0) return 8'h00;
    if (c < 13) return 8'(2 + 3 * c);
    if (c < 24) return 8'(38 + 6 * (c - 12));
    return 8'(104 + 12 * (c - 23));
  endfunction
  task automatic d(input logic l, input int n);
    ldc_host_model_inst.drv(l, n);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic results;
    $display("miscompares=%0d samples_checked=%0d", miscompares,
      samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic s_enter(input int st, input int ln, input logic exp);
    d(1'b1, st);
    d(1'b0, ln);
    #1;
    chk(wire_mode_o, exp, "mode early");
    d(1'b1, 1100);
    #1;
    chk(wire_mode_o, exp, "mode");
    chk(switch_en_o, 1, "enable");
  endtask
  task automatic s_shut;
    d(1'b0, SH - 10);
    #1;
    chk(shutdown_o, 0, "early shutdown");
    d(1'b0, 40);
    #1;
    chk(shutdown_o, 1, "no shutdown");
    chk(switch_en_o, 0, "switch");
    chk(ref_mv_o, 0, "ref");
  endtask
  task automatic s_pwm;
    #1;
    chk(ref_mv_o, 8'hC8, "full ref");
    for (int h = 2; h <= 6; h += 2) begin
      repeat (60) begin
        d(1'b1, h);
        d(1'b0, 8 - h);
      end
      #1;
      samples_checked++;
      if (^ref_mv_o === 1'bx || ref_mv_o < 25 * h - 20
        || ref_mv_o > 25 * h + 20) begin
        miscompares++;
        $display("[FAIL] %0t pwm level", $time);
      end
    end
    d(1'b0, 250);
    d(1'b1, 50);
    #1;
    chk(wire_mode_o, 0, "mode changed");
  endtask
  task automatic s_frame(input logic [7:0] a, input logic [7:0] dt,
    input int u, input int code, input int n_acc, input int n_oe);
    int a0;
    int o0;
    a0 = acc_n;
    o0 = oe_n;
    ldc_host_model_inst.frame(a, dt, u);
    #1;
    chk(bright_code_o, 8'(code), "code");
    chk(ref_mv_o, lut(code), "ref");
    chk(8'(acc_n - a0), 8'(n_acc), "accepts");
    chk(8'(oe_n - o0), 8'(n_oe), "ack cycles");
  endtask
  task automatic s_codes;
    for (int c = 0; c < 32; c++) s_frame(8'h72, 8'(c), 10, c, 1, 0);
  endtask
  task automatic s_rates;
    s_frame(8'h72, 8'h04, 4, 4, 1, 0);
    s_frame(8'h72, 8'h08, 40, 8, 1, 0);
  endtask
  task automatic s_reject;
    s_frame(8'h73, 8'h85, 10, 8, 0, 0);
    s_frame(8'h72, 8'hA5, 10, 8, 0, 0);
    s_frame(8'h72, 8'hC5, 10, 8, 0, 0);
  endtask
  task automatic s_ack;
    s_frame(8'h72, 8'h83, 10, 3, 1, ACK);
  endtask
  // ==========
  // Clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(shutdown_o, 1, "reset state");
    chk(bright_code_o, 8'h1F, "reset code");
    @(posedge clk);
    rstn <= 1'b1;
    s_enter(20, 250, 1'b0);
    s_pwm();
    s_shut();
    s_enter(850, 250, 1'b0);
    s_shut();
    s_enter(150, 250, 1'b1);
    chk(bright_code_o, 8'h1F, "first code");
    chk(ref_mv_o, 8'hC8, "first ref");
    s_codes();
    s_rates();
    s_reject();
    s_ack();
    s_shut();
    chk(bright_code_o, 8'h03, "code kept");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(bright_code_o, 8'h1F, "code after reset");
    s_enter(20, 250, 1'b0);
    results();
  end
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule // tb_ldc_top
